/* core/jtap_pkg.sv */
// Shared constants and types for the test access port block.
// Assumes a test clock well below the core clock and a separate
// active-low test reset that may arrive at any time.
package jtap_pkg;

  // ----------------------------------------------------------------
  // Register widths
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int USER_W = 16;

  // ----------------------------------------------------------------
  // Instruction codes and values after reset
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_USER = 4'h8;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = IR_IDCODE;
  localparam logic [USER_W-1:0] USER_CTRL_RESET = 16'h0000;
  localparam logic [ID_W-1:0] DR_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Data register selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DRSEL_BYPASS = 2'h0,
    DRSEL_ID = 2'h1,
    DRSEL_USER = 2'h2
  } jtap_drsel_t;

  // ----------------------------------------------------------------
  // Test controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jtap_state_t;

  // ----------------------------------------------------------------
  // Global pin controls carried to the rest of the chip
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pins_oe;
    logic scan_mode_n;
    logic core_reset_n;
  } jtap_pinctl_t;

endpackage

/* core/jtap_sync2.sv */
// Two-stage synchroniser with asynchronous active-low clear.
// Assumes the clear may assert at any time; release is taken up
// by the two stages so it leaves on a clock edge.
module jtap_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and clear
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // First stage feeds only the second
  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // Both stages clear at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule

/* core/jtap_port.sv */
// Test access port: serial test controller on its own clock, plus
// the global tristate, scan test and device reset controls.
// Assumes the tester keeps test reset high while it uses the port.
//
// Behaviour
// - Mode select steers controller on rising edges
// - Data in shifts into selected register
// - Data out changes on falling test clock
// - Data out tristated unless a register shifts
// - Tristate switching only after falling edge, except at once on test reset
// - Test reset holds controller reset, asynchronously
// - Test reset forces data out high impedance
// - Both pins low tristates all outputs asynchronously
// - Scan enable low enters scan mode asynchronously
// - Device reset low resets logic asynchronously
module jtap_port #(
  parameter logic [jtap_pkg::ID_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary
) (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial test port
  input wire logic test_port_clock,
  input wire logic test_port_reset_n,
  input wire logic test_mode_select_in,
  input wire logic test_serial_data_in,
  output logic test_serial_data_out,
  output logic test_serial_data_oe,
  // Global test pins
  input wire logic global_tristate_n,
  input wire logic scan_test_n,
  input wire logic device_reset_n,
  output jtap_pkg::jtap_pinctl_t pin_ctl,
  // Core side user register
  input wire logic [jtap_pkg::USER_W-1:0] core_status,
  output logic [jtap_pkg::USER_W-1:0] core_ctrl
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  jtap_pkg::jtap_state_t state;
  jtap_pkg::jtap_state_t next_state;
  logic [jtap_pkg::IR_W-1:0] ir_sh;
  logic [jtap_pkg::IR_W-1:0] next_ir_sh;
  logic [jtap_pkg::IR_W-1:0] ir;
  logic [jtap_pkg::IR_W-1:0] next_ir;
  logic [jtap_pkg::ID_W-1:0] dr_sh;
  logic [jtap_pkg::ID_W-1:0] next_dr_sh;
  logic [jtap_pkg::USER_W-1:0] user_reg;
  logic [jtap_pkg::USER_W-1:0] next_user_reg;
  logic upd_tgl;
  logic next_upd_tgl;
  logic [jtap_pkg::USER_W-1:0] status_cap;
  logic [jtap_pkg::USER_W-1:0] next_status_cap;
  logic snap_ack;
  logic next_snap_ack;
  logic snap_req_sync;
  logic next_tdo;
  logic next_tdo_oe;
  logic snap_req;
  logic next_snap_req;
  logic [jtap_pkg::USER_W-1:0] snap_word;
  logic [jtap_pkg::USER_W-1:0] next_snap_word;
  logic [1:0] xfer_meta;
  logic [1:0] xfer_sync;
  logic [1:0] next_xfer_meta;
  logic [1:0] next_xfer_sync;
  logic upd_seen;
  logic next_upd_seen;
  logic [jtap_pkg::USER_W-1:0] next_core_ctrl;
  logic hiz_release_n;
  logic scan_q;
  logic oe_q;
  logic rst_q;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Instruction to data register decode, unknown codes give bypass
  function automatic jtap_pkg::jtap_drsel_t dr_sel(
    input logic [jtap_pkg::IR_W-1:0] code
  );
    if (code == jtap_pkg::IR_IDCODE) begin
      return jtap_pkg::DRSEL_ID;
    end else if (code == jtap_pkg::IR_USER) begin
      return jtap_pkg::DRSEL_USER;
    end else begin
      return jtap_pkg::DRSEL_BYPASS;
    end
  endfunction

  // ----------------------------------------------------------------
  // Test controller state machine
  // ----------------------------------------------------------------
  // Mode select picks the next state
  always_comb begin
    next_state = state;
    unique case (state)
      jtap_pkg::ST_RESET: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_RESET
                                         : jtap_pkg::ST_IDLE;
      end
      jtap_pkg::ST_IDLE: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_SEL_DR
                                         : jtap_pkg::ST_IDLE;
      end
      jtap_pkg::ST_SEL_DR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_SEL_IR
                                         : jtap_pkg::ST_CAP_DR;
      end
      jtap_pkg::ST_CAP_DR, jtap_pkg::ST_SH_DR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_EX1_DR
                                         : jtap_pkg::ST_SH_DR;
      end
      jtap_pkg::ST_EX1_DR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_UPD_DR
                                         : jtap_pkg::ST_PA_DR;
      end
      jtap_pkg::ST_PA_DR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_EX2_DR
                                         : jtap_pkg::ST_PA_DR;
      end
      jtap_pkg::ST_EX2_DR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_UPD_DR
                                         : jtap_pkg::ST_SH_DR;
      end
      jtap_pkg::ST_UPD_DR, jtap_pkg::ST_UPD_IR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_SEL_DR
                                         : jtap_pkg::ST_IDLE;
      end
      jtap_pkg::ST_SEL_IR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_RESET
                                         : jtap_pkg::ST_CAP_IR;
      end
      jtap_pkg::ST_CAP_IR, jtap_pkg::ST_SH_IR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_EX1_IR
                                         : jtap_pkg::ST_SH_IR;
      end
      jtap_pkg::ST_EX1_IR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_UPD_IR
                                         : jtap_pkg::ST_PA_IR;
      end
      jtap_pkg::ST_PA_IR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_EX2_IR
                                         : jtap_pkg::ST_PA_IR;
      end
      jtap_pkg::ST_EX2_IR: begin
        next_state = test_mode_select_in ? jtap_pkg::ST_UPD_IR
                                         : jtap_pkg::ST_SH_IR;
      end
      default: begin
        next_state = jtap_pkg::ST_RESET; // Illegal one-hot code
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Instruction and data registers
  // ----------------------------------------------------------------
  // Capture, shift and update per the selected path
  always_comb begin
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_dr_sh = dr_sh;
    next_user_reg = user_reg;
    next_upd_tgl = upd_tgl;
    if (state == jtap_pkg::ST_RESET) begin
      next_ir = jtap_pkg::IR_RESET;
    end
    if (state == jtap_pkg::ST_CAP_IR) begin
      next_ir_sh = jtap_pkg::IR_CAPTURE;
    end
    if (state == jtap_pkg::ST_SH_IR) begin
      next_ir_sh = {test_serial_data_in, ir_sh[jtap_pkg::IR_W-1:1]};
    end
    if (state == jtap_pkg::ST_UPD_IR) begin
      next_ir = ir_sh;
    end
    if (state == jtap_pkg::ST_CAP_DR) begin
      unique case (dr_sel(ir))
        jtap_pkg::DRSEL_ID: next_dr_sh = ID_CODE;
        jtap_pkg::DRSEL_USER: next_dr_sh = {16'h0000, status_cap};
        jtap_pkg::DRSEL_BYPASS: next_dr_sh = jtap_pkg::DR_RESET;
      endcase
    end
    if (state == jtap_pkg::ST_SH_DR) begin
      unique case (dr_sel(ir))
        jtap_pkg::DRSEL_ID: begin
          next_dr_sh = {test_serial_data_in, dr_sh[31:1]};
        end
        jtap_pkg::DRSEL_USER: begin
          next_dr_sh[15:0] = {test_serial_data_in, dr_sh[15:1]};
        end
        jtap_pkg::DRSEL_BYPASS: begin
          next_dr_sh[0] = test_serial_data_in;
        end
      endcase
    end
    if (state == jtap_pkg::ST_UPD_DR
        && dr_sel(ir) == jtap_pkg::DRSEL_USER) begin
      next_user_reg = dr_sh[15:0];
      next_upd_tgl = ~upd_tgl;
    end
  end

  // Status snapshot taken from the core side
  always_comb begin
    next_status_cap = status_cap;
    next_snap_ack = snap_ack;
    if (snap_req_sync != snap_ack) begin
      next_status_cap = snap_word;
      next_snap_ack = snap_req_sync;
    end
  end

  // Rising test clock; test reset clears asynchronously
  always_ff @(posedge test_port_clock or negedge test_port_reset_n) begin
    if (!test_port_reset_n) begin
      state <= jtap_pkg::ST_RESET;
      ir_sh <= jtap_pkg::IR_CAPTURE;
      ir <= jtap_pkg::IR_RESET;
      dr_sh <= jtap_pkg::DR_RESET;
      user_reg <= jtap_pkg::USER_CTRL_RESET;
      upd_tgl <= 1'b0;
      status_cap <= jtap_pkg::USER_CTRL_RESET;
      snap_ack <= 1'b0;
    end else begin
      state <= next_state;
      ir_sh <= next_ir_sh;
      ir <= next_ir;
      dr_sh <= next_dr_sh;
      user_reg <= next_user_reg;
      upd_tgl <= next_upd_tgl;
      status_cap <= next_status_cap;
      snap_ack <= next_snap_ack;
    end
  end

  // Snapshot request into the test clock domain
  jtap_sync2 #(.WIDTH(1)) u_req_sync (
    .clk(test_port_clock),
    .arst_n(test_port_reset_n),
    .d(snap_req),
    .q(snap_req_sync)
  );

  // ----------------------------------------------------------------
  // Serial data output
  // ----------------------------------------------------------------
  // Output stage of the shifting register, driven only when shifting
  always_comb begin
    next_tdo = (state == jtap_pkg::ST_SH_IR) ? ir_sh[0] : dr_sh[0];
    next_tdo_oe = (state == jtap_pkg::ST_SH_IR)
                  || (state == jtap_pkg::ST_SH_DR);
  end

  // Falling test clock; test reset forces high impedance
  always_ff @(negedge test_port_clock or negedge test_port_reset_n) begin
    if (!test_port_reset_n) begin
      test_serial_data_out <= 1'b0;
      test_serial_data_oe <= 1'b0;
    end else begin
      test_serial_data_out <= next_tdo;
      test_serial_data_oe <= next_tdo_oe;
    end
  end

  // ----------------------------------------------------------------
  // Core clock side of the crossings
  // ----------------------------------------------------------------
  // Snapshot waits for acknowledge; update toggle loads control word
  always_comb begin
    next_xfer_meta = {upd_tgl, snap_ack};
    next_xfer_sync = xfer_meta;
    next_snap_req = snap_req;
    next_snap_word = snap_word;
    next_upd_seen = upd_seen;
    next_core_ctrl = core_ctrl;
    if (xfer_sync[0] == snap_req) begin
      next_snap_word = core_status;
      next_snap_req = ~snap_req;
    end
    if (xfer_sync[1] != upd_seen) begin
      next_core_ctrl = user_reg; // Held stable since the toggle
      next_upd_seen = xfer_sync[1];
    end
  end

  // Core clock registers, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xfer_meta <= 2'h0;
      xfer_sync <= 2'h0;
      snap_req <= 1'b0;
      snap_word <= jtap_pkg::USER_CTRL_RESET;
      upd_seen <= 1'b0;
      core_ctrl <= jtap_pkg::USER_CTRL_RESET;
    end else begin
      xfer_meta <= next_xfer_meta;
      xfer_sync <= next_xfer_sync;
      snap_req <= next_snap_req;
      snap_word <= next_snap_word;
      upd_seen <= next_upd_seen;
      core_ctrl <= next_core_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Global test pins
  // ----------------------------------------------------------------
  // Tristate request needs both pins low; tester keeps reset high
  assign hiz_release_n = global_tristate_n | test_port_reset_n;

  // Output enables drop at once, return on the core clock
  jtap_sync2 #(.WIDTH(1)) u_hiz_sync (
    .clk(ref_clk), .arst_n(hiz_release_n), .d(1'b1), .q(oe_q)
  );

  // Scan mode enters at once, leaves on the core clock
  jtap_sync2 #(.WIDTH(1)) u_scan_sync (
    .clk(ref_clk), .arst_n(scan_test_n), .d(1'b1), .q(scan_q)
  );

  // Device reset asserts at once, releases on the core clock
  jtap_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk(ref_clk), .arst_n(device_reset_n), .d(1'b1), .q(rst_q)
  );

  // Pin controls straight from the synchroniser outputs
  assign pin_ctl = '{pins_oe: oe_q, scan_mode_n: scan_q,
                     core_reset_n: rst_q};

endmodule

/* verification/jtap_port_assertions.sv */
// Checker for the test access port, bound to every jtap_port.
// Assumes the test clock is several ref_clk cycles per phase.
module jtap_port_assertions (
  // Clocks and resets
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic test_port_clock,
  input wire logic test_port_reset_n,
  // Serial test port
  input wire logic test_mode_select_in,
  input wire logic test_serial_data_in,
  input wire logic test_serial_data_out,
  input wire logic test_serial_data_oe,
  // Global pins and core side
  input wire logic global_tristate_n,
  input wire logic scan_test_n,
  input wire logic device_reset_n,
  input wire jtap_pkg::jtap_pinctl_t pin_ctl,
  input wire logic [jtap_pkg::USER_W-1:0] core_status,
  input wire logic [jtap_pkg::USER_W-1:0] core_ctrl
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  AST_TDO_FALL: assert property (@(posedge ref_clk)
    disable iff (!test_port_reset_n)
    !$stable(test_serial_data_out) |-> !test_port_clock)
    else $error("data out moved while test clock high");
  AST_OE_FALL: assert property (@(posedge ref_clk)
    disable iff (!test_port_reset_n)
    !$stable(test_serial_data_oe) |-> !test_port_clock)
    else $error("data out enable moved while test clock high");
  AST_TRST_HIZ: assert property (@(posedge ref_clk)
    disable iff (!rst_n) !test_port_reset_n |-> !test_serial_data_oe)
    else $error("data out driven during test reset");
  AST_TRST_CLR: assert property (@(posedge ref_clk)
    disable iff (!rst_n) !test_port_reset_n |-> !test_serial_data_out)
    else $error("data out not cleared during test reset");
  AST_IR_WALK: assert property (@(posedge test_port_clock)
    disable iff (!test_port_reset_n)
    test_mode_select_in [*5] ##1 !test_mode_select_in ##1
    test_mode_select_in [*2] ##1 !test_mode_select_in [*2]
    |=> test_serial_data_oe)
    else $error("no drive after entering instruction shift");
  AST_TMS_RESET: assert property (@(posedge test_port_clock)
    disable iff (!test_port_reset_n)
    test_mode_select_in [*5] |=> !test_serial_data_oe)
    else $error("data out driven after controller reset");
  // ----------------------------------------------------------------
  // Global pins
  // ----------------------------------------------------------------
  AST_PINS_HIZ: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !global_tristate_n && !test_port_reset_n |-> !pin_ctl.pins_oe)
    else $error("outputs enabled under global tristate");
  AST_SCAN: assert property (@(posedge ref_clk)
    disable iff (!rst_n) !scan_test_n |-> !pin_ctl.scan_mode_n)
    else $error("scan mode not entered");
  AST_CORE_RST: assert property (@(posedge ref_clk)
    disable iff (!rst_n) !device_reset_n |-> !pin_ctl.core_reset_n)
    else $error("core reset not asserted");
  AST_RST_REL: assert property (@(posedge ref_clk)
    disable iff (!rst_n) $rose(device_reset_n)
    |-> !pin_ctl.core_reset_n [*2] ##1 pin_ctl.core_reset_n)
    else $error("core reset release not two cycles");
  // Main scenarios reached
  COV_OE: cover property (@(posedge ref_clk) $rose(test_serial_data_oe));
  COV_HIZ: cover property (@(posedge ref_clk) $fell(pin_ctl.pins_oe));
  COV_CTRL: cover property (@(posedge ref_clk) !$stable(core_ctrl));
endmodule

bind jtap_port jtap_port_assertions jtap_port_assertions_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .test_port_clock(test_port_clock),
  .test_port_reset_n(test_port_reset_n),
  .test_mode_select_in(test_mode_select_in),
  .test_serial_data_in(test_serial_data_in),
  .test_serial_data_out(test_serial_data_out),
  .test_serial_data_oe(test_serial_data_oe),
  .global_tristate_n(global_tristate_n), .scan_test_n(scan_test_n),
  .device_reset_n(device_reset_n), .pin_ctl(pin_ctl),
  .core_status(core_status), .core_ctrl(core_ctrl)
);

/* verification/jtap_tester.sv */
// Model of the external boundary-scan tester driving the test port.
// Assumes the test clock stands low between frames.
module jtap_tester (
  // Serial port driven by the tester
  output logic test_port_clock,
  output logic test_port_reset_n,
  output logic test_mode_select_in,
  output logic test_serial_data_in,
  // Serial port returned by the device
  input wire logic test_serial_data_out,
  input wire logic test_serial_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_tdo;
  int oe_bad;
  // Power-up levels, pulled-up lines idle high
  initial begin
    test_port_clock = 1'b0;
    test_port_reset_n = 1'b0;
    test_mode_select_in = 1'b1;
    test_serial_data_in = 1'b1;
    oe_bad = 0;
  end
  // One 64 ns test clock period, data out taken before the rise
  task automatic tick(input logic m, input logic d);
    test_mode_select_in = m;
    test_serial_data_in = d;
    #13;
    // Released line floats; the inverse makes a missing drive visible
    last_tdo = test_serial_data_oe ? test_serial_data_out
                                   : ~test_serial_data_out;
    test_port_clock = 1'b1;
    #32;
    test_port_clock = 1'b0;
    #19;
  endtask
  // Test reset level, held high through every access except the mid-shift reset test and the global pin test
  task automatic set_trst(input logic v);
    test_port_reset_n = v;
  endtask
  // Five ones reach reset, then one zero parks in idle
  task automatic go_idle;
    repeat (5) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask
  // Scan from idle back to idle, least significant bit first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = 32'h0000_0000;
    tick(1'b1, 1'b1);
    if (ir) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      if (test_serial_data_oe !== 1'b1) oe_bad++;
      tick(i == n - 1, din[i]);
      dout[i] = last_tdo;
    end
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for jtap_port with the tester model.
// Assumes the checker is bound in from its own file.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ID = 32'h0000_0001; // arbitrary value
  logic ref_clk, rst_n, global_tristate_n, scan_test_n, device_reset_n;
  logic test_port_clock, test_port_reset_n, test_mode_select_in;
  logic test_serial_data_in, test_serial_data_out, test_serial_data_oe;
  jtap_pkg::jtap_pinctl_t pin_ctl;
  logic [jtap_pkg::USER_W-1:0] core_status, core_ctrl;
  logic [31:0] dout;
  int n_mismatch, compares;
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("wrong value %s exp %0h got %0h", nm, exp, got); \
  end end
  // Device and tester
  jtap_port #(.ID_CODE(ID)) jtap_port_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .test_port_clock(test_port_clock),
    .test_port_reset_n(test_port_reset_n),
    .test_mode_select_in(test_mode_select_in),
    .test_serial_data_in(test_serial_data_in),
    .test_serial_data_out(test_serial_data_out),
    .test_serial_data_oe(test_serial_data_oe),
    .global_tristate_n(global_tristate_n), .scan_test_n(scan_test_n),
    .device_reset_n(device_reset_n), .pin_ctl(pin_ctl),
    .core_status(core_status), .core_ctrl(core_ctrl));
  jtap_tester jtap_tester_inst (
    .test_port_clock(test_port_clock),
    .test_port_reset_n(test_port_reset_n),
    .test_mode_select_in(test_mode_select_in),
    .test_serial_data_in(test_serial_data_in),
    .test_serial_data_out(test_serial_data_out),
    .test_serial_data_oe(test_serial_data_oe));
  // Core clock, 8 ns
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Verdict and end of run
  task end_sim;
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Identity word after reset, drive only while shifting
  task t_id;
    jtap_tester_inst.scan(1'b0, 32, 32'h0000_0000, dout);
    `CHK("id word", ID, dout)
    `CHK("oe in shift", 0, jtap_tester_inst.oe_bad)
    `CHK("oe in idle", 1'b0, test_serial_data_oe)
  endtask
  // User register: capture status, update control
  task t_user;
    jtap_tester_inst.go_idle;
    jtap_tester_inst.scan(1'b1, 4, {28'h0, jtap_pkg::IR_USER}, dout);
    `CHK("ir capture", {28'h0, jtap_pkg::IR_CAPTURE}, dout)
    jtap_tester_inst.scan(1'b0, 16, 32'h0000_A5C3, dout);
    `CHK("status", {16'h0, core_status}, dout)
    repeat (8) @(negedge ref_clk);
    `CHK("ctrl", 16'hA5C3, core_ctrl)
  endtask
  // Bypass and an unused code both give a one-bit path
  task t_bypass;
    logic [3:0] codes [2];
    codes[0] = jtap_pkg::IR_BYPASS;
    codes[1] = 4'h3;
    for (int k = 0; k < 2; k++) begin
      jtap_tester_inst.scan(1'b1, 4, {28'h0, codes[k]}, dout);
      jtap_tester_inst.scan(1'b0, 8, 32'h0000_00B6, dout);
      `CHK("bypass", 32'h0000_006C, dout)
    end
  endtask
  // Test reset in mid shift
  task t_trst;
    jtap_tester_inst.tick(1'b1, 1'b1);
    jtap_tester_inst.tick(1'b0, 1'b1);
    jtap_tester_inst.tick(1'b0, 1'b1);
    jtap_tester_inst.tick(1'b0, 1'b0);
    `CHK("oe shifting", 1'b1, test_serial_data_oe)
    jtap_tester_inst.set_trst(1'b0);
    #1;
    `CHK("oe at reset", 1'b0, test_serial_data_oe)
    jtap_tester_inst.tick(1'b0, 1'b1);
    `CHK("oe held", 1'b0, test_serial_data_oe)
    jtap_tester_inst.set_trst(1'b1);
    jtap_tester_inst.tick(1'b0, 1'b1);
    t_id;
  endtask
  // Global tristate, scan enable and device reset
  task t_pins;
    @(negedge ref_clk);
    global_tristate_n = 1'b0;
    @(negedge ref_clk);
    `CHK("pins_oe alone", 1'b1, pin_ctl.pins_oe)
    jtap_tester_inst.set_trst(1'b0);
    scan_test_n = 1'b0;
    device_reset_n = 1'b0;
    #1;
    `CHK("pins_oe", 1'b0, pin_ctl.pins_oe)
    `CHK("scan mode", 1'b0, pin_ctl.scan_mode_n)
    `CHK("core reset", 1'b0, pin_ctl.core_reset_n)
    @(negedge ref_clk);
    global_tristate_n = 1'b1;
    scan_test_n = 1'b1;
    device_reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK("pins_oe back", 1'b1, pin_ctl.pins_oe)
    `CHK("scan back", 1'b1, pin_ctl.scan_mode_n)
    `CHK("core back", 1'b1, pin_ctl.core_reset_n)
    jtap_tester_inst.set_trst(1'b1);
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    global_tristate_n = 1'b1;
    scan_test_n = 1'b1;
    device_reset_n = 1'b1;
    core_status = 16'h3C5A;
    n_mismatch = 0;
    compares = 0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    jtap_tester_inst.set_trst(1'b1);
    jtap_tester_inst.go_idle;
    t_id;
    t_user;
    t_bypass;
    t_trst;
    t_pins;
    end_sim;
  end
  // Watchdog well past the expected run
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
endmodule
